// ### hdl/mbw_consts.svh
// Constants of the serial write and loopback command handler.
// Included by the gap timer, holding store and handler files; definitions only.
`ifndef MBW_CONSTS_SVH
`define MBW_CONSTS_SVH

// ----------------------------------------------------------------
// Function and error codes
// ----------------------------------------------------------------
`define MBW_FC_WR_ONE    8'h06
`define MBW_FC_LOOP      8'h08
`define MBW_FC_WR_MULTI  8'h10
`define MBW_FC_ERR_FLAG  8'h80
`define MBW_ERR_FUNC     8'h01
`define MBW_ERR_ADDR     8'h02
`define MBW_ERR_COUNT    8'h03
`define MBW_ERR_NONE     8'h00
`define MBW_BCAST        8'h00
`define MBW_SUBF_ECHO    16'h0000

// ----------------------------------------------------------------
// Holding word map
// ----------------------------------------------------------------
`define MBW_WORDS        400
`define MBW_REG_LAST     16'h018f
`define MBW_MULTI_MAX    16'h0020
`define MBW_ADDR_VT_LO   9'h0c8
`define MBW_ADDR_VT_HI   9'h0c9
`define MBW_ADDR_CT_LO   9'h0ca
`define MBW_ADDR_CT_HI   9'h0cb
`define MBW_ADDR_COMMIT  9'h0ce
`define MBW_ADDR_INTEG   9'h12d
`define MBW_COMMIT_VAL   16'h0001
`define MBW_RATIO_RST    32'h3f800000
`define MBW_INTEG_RST    16'h0000

// ----------------------------------------------------------------
// Framing characters and frame buffer
// ----------------------------------------------------------------
`define MBW_CH_COLON     8'h3a
`define MBW_CH_CR        8'h0d
`define MBW_CH_LF        8'h0a
`define MBW_BUF_LEN      80
`define MBW_BUF_LAST     7'h4f

// ----------------------------------------------------------------
// Inter-character gap limit
// ----------------------------------------------------------------
`define MBW_GAP_MS       2000
`define MBW_CLK_KHZ      40000
`define MBW_GAP_CYC      (`MBW_GAP_MS * `MBW_CLK_KHZ)

`endif

// ### hdl/mbw_pkg.sv
// Types of the serial write and loopback command handler.
// Needs nothing from its surroundings.
package mbw_pkg;

	// Main sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_RECV,
		ST_CHECK,
		ST_EXEC,
		ST_REPLY
	} mbw_state_e;

	// Reply serialiser phases
	typedef enum logic [2:0]
	{
		TX_START,
		TX_BODY,
		TX_CHK,
		TX_CR,
		TX_LF,
		TX_DONE
	} mbw_txph_e;

endpackage

// ### hdl/mbw_gap_timer.sv
// Inter-character gap watchdog of the command handler.
// Assumes kick_i pulses once per received character.
`timescale 1ns/10ps
`include "mbw_consts.svh"

module mbw_gap_timer
#(
	parameter logic [26:0] GAP_CYC = 27'(`MBW_GAP_CYC)
)
(
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic resetn_i,
	// Control
	input  wire logic run_i,
	input  wire logic kick_i,
	// Status
	output logic      expire_o
);

	logic [26:0] cnt_r;
	logic        exp_r;

	// Cycles since the last character
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt_r <= 27'h0;
		else if (!run_i || kick_i)
			cnt_r <= 27'h0;
		else if (cnt_r != GAP_CYC)
			cnt_r <= cnt_r + 27'h1;
	end

	// One pulse when the gap is overrun
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			exp_r <= 1'b0;
		else
			exp_r <= run_i && !kick_i && (cnt_r == GAP_CYC - 27'h1);
	end

	assign expire_o = exp_r;

endmodule

// ### hdl/mbw_holding.sv
// Holding word store with staged transformer ratio settings.
// Assumes one word write per cycle from the command handler.
`timescale 1ns/10ps
`include "mbw_consts.svh"

module mbw_holding
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	// Word write port
	input  wire logic        we_i,
	input  wire logic [8:0]  waddr_i,
	input  wire logic [15:0] wdata_i,
	// Active settings
	output logic      [31:0] voltage_transformer_ratio_o,
	output logic      [31:0] current_transformer_ratio_o,
	output logic      [15:0] integ_ctrl_o
);

	logic [15:0] mem [0:`MBW_WORDS-1];
	logic        pend_r;
	logic [31:0] vt_r;
	logic [31:0] ct_r;
	logic [15:0] integ_r;

	// Word storage, no reset
	always_ff @(posedge ref_clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end

	// Commit request from a write of one to the commit word
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pend_r <= 1'b0;
		else
			pend_r <= we_i && (waddr_i == `MBW_ADDR_COMMIT)
				&& (wdata_i == `MBW_COMMIT_VAL); // [R13]
	end

	// Ratios switch only on commit; low word sits lower
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			vt_r <= `MBW_RATIO_RST;
			ct_r <= `MBW_RATIO_RST;
		end
		else if (pend_r)
		begin
			vt_r <= {mem[`MBW_ADDR_VT_HI], mem[`MBW_ADDR_VT_LO]}; // [R12] [R13]
			ct_r <= {mem[`MBW_ADDR_CT_HI], mem[`MBW_ADDR_CT_LO]};
		end
	end

	// Integration control word
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			integ_r <= `MBW_INTEG_RST;
		else if (we_i && (waddr_i == `MBW_ADDR_INTEG))
			integ_r <= wdata_i;
	end

	assign voltage_transformer_ratio_o   = vt_r;
	assign current_transformer_ratio_o   = ct_r;
	assign integ_ctrl_o = integ_r;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_ratio_commit: assert property ( // [R13]
		($changed(vt_r) || $changed(ct_r)) |-> $past(pend_r))
		else $error("ratio changed without commit");

endmodule

// ### hdl/mbw_handler.sv
// Serial write and loopback command handler, slave side.
// Assumes a character link below it: ASCII chars or RTU bytes,
// with RTU frame end and check verdict supplied by that link.
//
// Summary of operation
// [R01]: single write code 06 stores one data word into one addressed word
// [R02]: station 00 writes are accepted whatever our station number
// [R03]: broadcast writes execute and send nothing back
// [R04]: single write reply echoes the whole request, check included
// [R05]: master sends loopback subfunction zero then any test word
// [R06]: loopback request is returned unchanged
// [R07]: only subfunction 0000 is supported, data word is free
// [R08]: multi write covers at most 32 consecutive words
// [R09]: byte count follows register count and equals twice it
// [R10]: multi write reply holds station, code, start, count, new check
// [R11]: multi write travels as code hex 10
// [R12]: ratio low half in lower word, high half in next word
// [R13]: new ratios take effect only after one written to commit word
// [R14]: ASCII frames start with colon, end CR LF, bytes as hex pairs
// [R15]: RTU frames unmarked, fields upper byte first, two check bytes
// [R16]: error reply carries function code plus hex 80 and error code
// [R17]: unsupported function gives error code 01
// [R18]: word number outside range gives error code 02
// [R19]: gap over 2 seconds between characters discards the request
`timescale 1ns/10ps
`include "mbw_consts.svh"

module mbw_handler
#(
	parameter logic [26:0] GAP_CYC = 27'(`MBW_GAP_CYC)
)
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	// Configuration
	input  wire logic        ascii_mode_i,
	input  wire logic [7:0]  station_i,
	// Receive characters
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_err_i,
	input  wire logic        rx_end_i,
	input  wire logic        rx_crc_ok_i,
	// Transmit characters
	output logic             tx_valid_o,
	output logic      [7:0]  tx_data_o,
	output logic             tx_last_o,
	output logic             tx_crc_req_o,
	input  wire logic        tx_ready_i,
	// Settings and status
	output logic      [31:0] voltage_transformer_ratio_o,
	output logic      [31:0] current_transformer_ratio_o,
	output logic      [15:0] integ_ctrl_o,
	output logic             busy_o,
	output logic             frame_drop_o
);

	mbw_pkg::mbw_state_e st_r;
	mbw_pkg::mbw_txph_e  tx_ph_r;
	logic [7:0]  buf_r [0:`MBW_BUF_LEN-1];
	logic [6:0]  len_r;
	logic [7:0]  sum_r;
	logic [3:0]  nib_r;
	logic        hi_r, cr_r, bad_r, crc_ok_r;
	logic [5:0]  wptr_r, wcnt_r;
	logic [6:0]  wbase_r, tx_n_r, tx_idx_r;
	logic [8:0]  waddr_r;
	logic        bcast_r, rsp_err_r, newchk_r, tx_lo_r, drop_r;
	logic [7:0]  rsp_code_r, lrc_r, tx_data_r;
	logic        tx_valid_r, tx_last_r, tx_crc_r;
	logic        gap_exp, rx_start, rx_eof, slot, reply_done;
	logic [4:0]  hx;
	logic [7:0]  fc, cur, lrc_neg;
	logic [15:0] addr16, cnt16;
	logic [6:0]  plen, didx;
	logic        frame_ok, is_bc, mine, v_drop, v_write;
	logic [7:0]  v_code;
	logic [6:0]  v_base;
	logic [5:0]  v_cnt;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Hex character to {valid, nibble}
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b1, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			return {1'b1, 4'(c - 8'h37)};
		else
			return 5'h00;
	endfunction

	// Nibble to upper case hex character
	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------

	// Frame start and end detection
	assign hx       = hex_val(rx_data_i);
	assign rx_start = rx_valid_i && (ascii_mode_i
		? (rx_data_i == `MBW_CH_COLON && st_r inside
			{mbw_pkg::ST_IDLE, mbw_pkg::ST_RECV})
		: (st_r == mbw_pkg::ST_IDLE));                      // [R14] [R15]
	assign rx_eof   = (st_r == mbw_pkg::ST_RECV) && (ascii_mode_i
		? (rx_valid_i && cr_r && rx_data_i == `MBW_CH_LF) : rx_end_i);

	// Frame buffer, hex pairing and running byte sum
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			len_r <= 7'h0;
			sum_r <= 8'h0;
			nib_r <= 4'h0;
			hi_r  <= 1'b0;
			cr_r  <= 1'b0;
			bad_r <= 1'b0;
		end
		else if (rx_start)
		begin
			len_r <= ascii_mode_i ? 7'h0 : 7'h1;
			sum_r <= 8'h0;
			hi_r  <= 1'b0;
			cr_r  <= 1'b0;
			bad_r <= rx_err_i;
			if (!ascii_mode_i)
				buf_r[0] <= rx_data_i;
		end
		else if (st_r == mbw_pkg::ST_RECV && rx_valid_i && !rx_eof)
		begin
			if (rx_err_i || cr_r)
				bad_r <= 1'b1;
			if (ascii_mode_i && rx_data_i == `MBW_CH_CR)
				cr_r <= 1'b1;
			else if (ascii_mode_i && !hx[4])
				bad_r <= 1'b1;
			else if (ascii_mode_i && !hi_r)
			begin
				nib_r <= hx[3:0];
				hi_r  <= 1'b1;
			end
			else if (len_r > `MBW_BUF_LAST)
				bad_r <= 1'b1;
			else
			begin
				buf_r[len_r] <= ascii_mode_i ? {nib_r, hx[3:0]} : rx_data_i;
				sum_r        <= sum_r + {nib_r, hx[3:0]};
				len_r        <= len_r + 7'h1;
				hi_r         <= 1'b0;
			end
		end
	end

	// RTU check verdict captured with the frame end
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			crc_ok_r <= 1'b0;
		else if (st_r == mbw_pkg::ST_RECV && rx_end_i)
			crc_ok_r <= rx_crc_ok_i;
	end

	mbw_gap_timer #(.GAP_CYC(GAP_CYC)) u_gap
	(
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.run_i     (st_r == mbw_pkg::ST_RECV),
		.kick_i    (rx_valid_i),
		.expire_o  (gap_exp)
	);

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------

	// Field views of the received frame
	assign fc       = buf_r[1];
	assign addr16   = {buf_r[2], buf_r[3]};                // [R15]
	assign cnt16    = {buf_r[4], buf_r[5]};
	assign plen     = len_r - (ascii_mode_i ? 7'h1 : 7'h2);
	assign is_bc    = (buf_r[0] == `MBW_BCAST);
	assign mine     = (buf_r[0] == station_i);
	assign frame_ok = !bad_r && !hi_r && (len_r >= 7'h4)
		&& (ascii_mode_i ? (sum_r == 8'h00) : crc_ok_r);

	// Verdict on a complete frame
	always_comb
	begin
		v_drop  = 1'b0;
		v_write = 1'b0;
		v_code  = `MBW_ERR_NONE;
		v_base  = 7'h4;
		v_cnt   = 6'h1;
		if (!frame_ok || (!is_bc && !mine))
			v_drop = 1'b1;                                  // [R02]
		else
			case (fc)
				`MBW_FC_WR_ONE:
					if (plen != 7'h6)
						v_drop = 1'b1;
					else if (addr16 > `MBW_REG_LAST)
						v_code = `MBW_ERR_ADDR;                 // [R18]
					else
						v_write = 1'b1;                         // [R01]
				`MBW_FC_LOOP:
					if (plen != 7'h6 || is_bc)
						v_drop = 1'b1;
					else if (addr16 != `MBW_SUBF_ECHO)
						v_code = `MBW_ERR_FUNC;                 // [R07]
				`MBW_FC_WR_MULTI:                               // [R11]
					if ({2'b00, plen} != 9'h007 + {1'b0, buf_r[6]})
						v_drop = 1'b1;
					else if (cnt16 == 16'h0 || cnt16 > `MBW_MULTI_MAX
						|| buf_r[6] != {cnt16[6:0], 1'b0})
						v_code = `MBW_ERR_COUNT;                // [R08] [R09]
					else if ({1'b0, addr16} + {1'b0, cnt16} - 17'h1
						> {1'b0, `MBW_REG_LAST})
						v_code = `MBW_ERR_ADDR;                 // [R18]
					else
					begin
						v_write = 1'b1;
						v_base  = 7'h7;
						v_cnt   = cnt16[5:0];
					end
				default:
					v_code = `MBW_ERR_FUNC;                     // [R17]
			endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	// Main state
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_r <= mbw_pkg::ST_IDLE;
		else
			case (st_r)
				mbw_pkg::ST_IDLE:
					if (rx_start)
						st_r <= mbw_pkg::ST_RECV;
				mbw_pkg::ST_RECV:
					if (gap_exp)
						st_r <= mbw_pkg::ST_IDLE;               // [R19]
					else if (rx_eof)
						st_r <= mbw_pkg::ST_CHECK;
				mbw_pkg::ST_CHECK:
					if (v_drop || (v_code != `MBW_ERR_NONE && is_bc))
						st_r <= mbw_pkg::ST_IDLE;               // [R03]
					else if (v_code != `MBW_ERR_NONE)
						st_r <= mbw_pkg::ST_REPLY;
					else if (v_write)
						st_r <= mbw_pkg::ST_EXEC;
					else
						st_r <= mbw_pkg::ST_REPLY;              // [R06]
				mbw_pkg::ST_EXEC:
					if (wptr_r == wcnt_r - 6'h1)
						st_r <= bcast_r ? mbw_pkg::ST_IDLE      // [R03]
							: mbw_pkg::ST_REPLY;
				mbw_pkg::ST_REPLY:
					if (reply_done)
						st_r <= mbw_pkg::ST_IDLE;
				default:
					st_r <= mbw_pkg::ST_IDLE;
			endcase
	end

	// Write job and reply shape, latched on the decision cycle
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wptr_r     <= 6'h0;
			wcnt_r     <= 6'h1;
			wbase_r    <= 7'h4;
			waddr_r    <= 9'h0;
			bcast_r    <= 1'b0;
			rsp_err_r  <= 1'b0;
			rsp_code_r <= `MBW_ERR_NONE;
			tx_n_r     <= 7'h0;
			newchk_r   <= 1'b0;
		end
		else if (st_r == mbw_pkg::ST_CHECK)
		begin
			wptr_r     <= 6'h0;
			wcnt_r     <= v_cnt;
			wbase_r    <= v_base;
			waddr_r    <= addr16[8:0];
			bcast_r    <= is_bc;
			rsp_err_r  <= (v_code != `MBW_ERR_NONE);
			rsp_code_r <= v_code;
			newchk_r   <= (v_code != `MBW_ERR_NONE)
				|| (fc == `MBW_FC_WR_MULTI);                    // [R10] [R16]
			tx_n_r     <= (v_code != `MBW_ERR_NONE) ? 7'h3
				: (fc == `MBW_FC_WR_MULTI) ? 7'h6 : len_r;  // [R04] [R10]
		end
		else if (st_r == mbw_pkg::ST_EXEC)
			wptr_r <= wptr_r + 6'h1;
	end

	// Discard indication
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			drop_r <= 1'b0;
		else
			drop_r <= (st_r == mbw_pkg::ST_RECV && gap_exp)
				|| (st_r == mbw_pkg::ST_CHECK && v_drop);
	end

	// Word writes, upper byte first in the data field
	assign didx = wbase_r + {wptr_r, 1'b0};

	mbw_holding u_hold
	(
		.ref_clk_i    (ref_clk_i),
		.resetn_i     (resetn_i),
		.we_i         (st_r == mbw_pkg::ST_EXEC),              // [R01]
		.waddr_i      (waddr_r + {3'h0, wptr_r}),
		.wdata_i      ({buf_r[didx], buf_r[didx + 7'h1]}),   // [R15]
		.voltage_transformer_ratio_o   (voltage_transformer_ratio_o),
		.current_transformer_ratio_o   (current_transformer_ratio_o),
		.integ_ctrl_o (integ_ctrl_o)
	);

	// ----------------------------------------------------------------
	// Reply serialiser
	// ----------------------------------------------------------------

	// Byte being sent: echo of the frame or error reply
	assign cur = !rsp_err_r ? buf_r[tx_idx_r]
		: (tx_idx_r == 7'h1) ? (fc | `MBW_FC_ERR_FLAG)         // [R16]
		: (tx_idx_r == 7'h2) ? rsp_code_r : buf_r[0];
	assign lrc_neg    = 8'h00 - lrc_r;
	assign slot       = !tx_valid_r || tx_ready_i;
	assign reply_done = (tx_ph_r == mbw_pkg::TX_DONE) && slot;

	// Character output register and phase
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_ph_r    <= mbw_pkg::TX_START;
			tx_idx_r   <= 7'h0;
			tx_lo_r    <= 1'b0;
			lrc_r      <= 8'h0;
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h0;
			tx_last_r  <= 1'b0;
			tx_crc_r   <= 1'b0;
		end
		else if (st_r != mbw_pkg::ST_REPLY)
		begin
			tx_ph_r  <= ascii_mode_i ? mbw_pkg::TX_START : mbw_pkg::TX_BODY;
			tx_idx_r <= 7'h0;
			tx_lo_r  <= 1'b0;
			lrc_r    <= 8'h0;
		end
		else if (slot)
		begin
			tx_valid_r <= (tx_ph_r != mbw_pkg::TX_DONE);
			tx_last_r  <= 1'b0;
			tx_crc_r   <= 1'b0;
			case (tx_ph_r)
				mbw_pkg::TX_START:
				begin
					tx_data_r <= `MBW_CH_COLON;                 // [R14]
					tx_ph_r   <= mbw_pkg::TX_BODY;
				end
				mbw_pkg::TX_BODY:
				begin
					tx_data_r <= !ascii_mode_i ? cur
						: hex_chr(tx_lo_r ? cur[3:0] : cur[7:4]);  // [R14]
					tx_lo_r   <= ascii_mode_i && !tx_lo_r;
					if (!ascii_mode_i || tx_lo_r)
					begin
						lrc_r    <= lrc_r + cur;
						tx_idx_r <= tx_idx_r + 7'h1;
					end
					if ((!ascii_mode_i || tx_lo_r) && tx_idx_r == tx_n_r - 7'h1)
					begin
						tx_last_r <= !ascii_mode_i;
						tx_crc_r  <= !ascii_mode_i && newchk_r;     // [R15]
						tx_ph_r   <= !ascii_mode_i ? mbw_pkg::TX_DONE
							: newchk_r ? mbw_pkg::TX_CHK : mbw_pkg::TX_CR;
					end
				end
				mbw_pkg::TX_CHK:
				begin
					tx_data_r <= hex_chr(tx_lo_r ? lrc_neg[3:0] : lrc_neg[7:4]);
					tx_lo_r   <= !tx_lo_r;
					if (tx_lo_r)
						tx_ph_r <= mbw_pkg::TX_CR;
				end
				mbw_pkg::TX_CR:
				begin
					tx_data_r <= `MBW_CH_CR;
					tx_ph_r   <= mbw_pkg::TX_LF;
				end
				mbw_pkg::TX_LF:
				begin
					tx_data_r <= `MBW_CH_LF;                    // [R14]
					tx_last_r <= 1'b1;
					tx_ph_r   <= mbw_pkg::TX_DONE;
				end
				default:
					tx_ph_r <= mbw_pkg::TX_DONE;
			endcase
		end
	end

	assign tx_valid_o   = tx_valid_r;
	assign tx_data_o    = tx_data_r;
	assign tx_last_o    = tx_last_r;
	assign tx_crc_req_o = tx_crc_r;
	assign busy_o       = (st_r != mbw_pkg::ST_IDLE);
	assign frame_drop_o = drop_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_multi_go;
		st_r == mbw_pkg::ST_CHECK && v_write && !v_drop
			&& fc == `MBW_FC_WR_MULTI;
	endsequence

	sequence s_multi_done;
		st_r == mbw_pkg::ST_EXEC && fc == `MBW_FC_WR_MULTI
			##1 st_r != mbw_pkg::ST_EXEC;
	endsequence

	chk_bcast_quiet: assert property ( // [R03]
		st_r == mbw_pkg::ST_REPLY |-> !bcast_r)
		else $error("reply started for a broadcast");
	chk_station_drop: assert property ( // [R02]
		(st_r == mbw_pkg::ST_CHECK && !is_bc && !mine)
			|=> st_r == mbw_pkg::ST_IDLE && frame_drop_o)
		else $error("foreign station frame not discarded");
	chk_one_write: assert property ( // [R01]
		(st_r == mbw_pkg::ST_CHECK && v_write && fc == `MBW_FC_WR_ONE)
			|=> st_r == mbw_pkg::ST_EXEC && wcnt_r == 6'h1
			&& waddr_r == $past(addr16[8:0]))
		else $error("single write not executed on its word");
	chk_multi_steps: assert property ( // [R08]
		s_multi_go |=> (st_r == mbw_pkg::ST_EXEC)[*1] ##0
			(wcnt_r == $past(cnt16[5:0]) && wcnt_r <= 6'h20))
		else $error("multi write job wrong");
	chk_multi_reply: assert property ( // [R10]
		s_multi_done ##0 (!bcast_r && !rsp_err_r)
			|-> st_r == mbw_pkg::ST_REPLY && tx_n_r == 7'h6 && newchk_r)
		else $error("multi write reply shape wrong");
	chk_echo_len: assert property ( // [R04] [R06]
		(st_r == mbw_pkg::ST_REPLY && !rsp_err_r && !newchk_r)
			|-> tx_n_r == len_r)
		else $error("echo reply length differs from request");
	chk_func_err: assert property ( // [R16] [R17]
		(st_r == mbw_pkg::ST_CHECK && !v_drop && !is_bc
			&& !(fc inside {`MBW_FC_WR_ONE, `MBW_FC_LOOP, `MBW_FC_WR_MULTI}))
			|=> st_r == mbw_pkg::ST_REPLY && rsp_code_r == `MBW_ERR_FUNC
			&& tx_n_r == 7'h3)
		else $error("unsupported function not answered with 01");
	chk_range_err: assert property ( // [R18]
		(st_r == mbw_pkg::ST_CHECK && !v_drop && fc == `MBW_FC_WR_ONE
			&& addr16 > `MBW_REG_LAST) |=> rsp_code_r == `MBW_ERR_ADDR)
		else $error("out of range word not answered with 02");
	chk_gap_drop: assert property ( // [R19]
		(st_r == mbw_pkg::ST_RECV && gap_exp)
			|=> st_r == mbw_pkg::ST_IDLE ##1 !tx_valid_o)
		else $error("gap overrun did not discard");
	chk_ascii_frame: assert property ( // [R14]
		(ascii_mode_i && $rose(tx_valid_o)) |-> tx_data_o == `MBW_CH_COLON)
		else $error("ASCII reply not opened by colon");

endmodule

// ### tb/mbw_master_model.sv
// Serial master stand-in: takes the handler's reply characters.
// Assumes the transmit handshake runs on ref_clk_i.
`timescale 1ns/10ps

module mbw_master_model
(
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	// Reply characters
	input  wire logic       slow_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	input  wire logic       tx_crc_i,
	output logic            tx_ready_o
);
	logic [7:0] got [0:255];
	logic [1:0] flg [0:255];
	int         n = 0;

	// Ready every cycle, or every other cycle when slow
	always_ff @(posedge ref_clk_i or negedge resetn_i)
		if (!resetn_i)
			tx_ready_o <= 1'b0;
		else
			tx_ready_o <= !slow_i || !tx_ready_o;

	// Collects taken characters; never waits on a broadcast
	always @(posedge ref_clk_i)
		if (resetn_i && tx_valid_i && tx_ready_o)
		begin
			got[n] = tx_data_i;
			flg[n] = {tx_last_i, tx_crc_i};
			n = n + 1;
		end
endmodule

// ### tb/mbw_handler_bench.sv
// Bench for the command handler, ASCII and RTU framing, station 0b.
// Assumes the master model above as the reply sink.
`timescale 1ns/10ps

module mbw_handler_bench;
	logic        ref_clk_i, resetn_i, rx_valid_i, slow, tx_ready_i;
	logic        ascii_mode_i, rx_err_i, rx_end_i, rx_crc_ok_i, tx_crc_req_o;
	logic [7:0]  rx_data_i, tx_data_o;
	logic        tx_valid_o, tx_last_o, busy_o, frame_drop_o;
	logic [31:0] voltage_transformer_ratio_o, current_transformer_ratio_o;
	logic [15:0] integ_ctrl_o;
	int          miscompares = 0, samples_checked = 0, base, w;

	// Device and master
	mbw_handler #(.GAP_CYC(27'd200)) mbw_handler_i (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .ascii_mode_i(ascii_mode_i),
		.station_i(8'h0b), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.rx_err_i(rx_err_i), .rx_end_i(rx_end_i), .rx_crc_ok_i(rx_crc_ok_i),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
		.tx_crc_req_o(tx_crc_req_o),
		.tx_ready_i(tx_ready_i), .voltage_transformer_ratio_o(voltage_transformer_ratio_o),
		.current_transformer_ratio_o(current_transformer_ratio_o), .integ_ctrl_o(integ_ctrl_o),
		.busy_o(busy_o), .frame_drop_o(frame_drop_o));
	mbw_master_model mbw_master_model_i (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_crc_i(tx_crc_req_o),
		.tx_ready_o(tx_ready_i));

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic send_raw(input string f);
		base = mbw_master_model_i.n;
		for (int i = 0; i < f.len(); i++)
		begin
			tick(1);
			rx_valid_i = 1'b1;
			rx_data_i = f[i];
		end
		tick(1);
		rx_valid_i = 1'b0;
	endtask

	task automatic send(input string s);
		send_raw({":", s, "\015\012"});
	endtask

	// RTU frame from hex pairs, then the frame end pulse
	task automatic send_rtu(input string s);
		base = mbw_master_model_i.n;
		for (int i = 0; i < s.len(); i += 2)
		begin
			tick(1);
			rx_valid_i = 1'b1;
			rx_data_i = 8'(s.substr(i, i + 1).atohex());
		end
		tick(1);
		rx_valid_i = 1'b0;
		rx_end_i = 1'b1;
		tick(1);
		rx_end_i = 1'b0;
	endtask

	task automatic expect_reply(input string s);
		string f;
		int    m;
		f = {":", s, "\015\012"};
		m = ascii_mode_i ? f.len() : s.len() / 2;
		w = 0;
		while (mbw_master_model_i.n - base < m && w < 600)
		begin
			tick(1);
			w++;
		end
		if (mbw_master_model_i.n - base < m)
		begin
			miscompares++;
			give_verdict();
		end
		for (int i = 0; i < m; i++)
			check(mbw_master_model_i.got[base + i], ascii_mode_i ? f[i]
				: s.substr(2 * i, 2 * i + 1).atohex());
		check(mbw_master_model_i.flg[base + m - 1][1], 1'b1);
		tick(2);
		check(busy_o, 1'b0);
	endtask

	// Discard pulse right after the frame end, then silence
	task automatic expect_drop();
		tick(1);
		check(frame_drop_o, 1'b1);
		expect_none();
	endtask

	task automatic expect_none();
		tick(100);
		check(mbw_master_model_i.n - base, 0);
		check(busy_o, 1'b0);
	endtask

	// 40 MHz clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// Main sequence
	initial
	begin
		resetn_i = 1'b0;
		rx_valid_i = 1'b0;
		rx_data_i = 8'h00;
		slow = 1'b0;
		ascii_mode_i = 1'b1;
		rx_err_i = 1'b0;
		rx_end_i = 1'b0;
		rx_crc_ok_i = 1'b1;
		tick(10);
		resetn_i = 1'b1;
		send("0B08000004D217");
		expect_reply("0B08000004D217");
		$display("test loopback done");
		slow = 1'b1;
		send("0B06012D0001C0");
		expect_reply("0B06012D0001C0");
		check(integ_ctrl_o, 16'h0001);
		slow = 1'b0;
		$display("test single write done");
		send("0B1000C800040800004120000041204F");
		expect_reply("0B1000C8000419");
		check(voltage_transformer_ratio_o, 32'h3f800000);
		send("0B0600CE000120");
		expect_reply("0B0600CE000120");
		check(voltage_transformer_ratio_o, 32'h41200000);
		check(current_transformer_ratio_o, 32'h41200000);
		$display("test multi write done");
		send("0006012D0002CA");
		expect_none();
		check(integ_ctrl_o, 16'h0002);
		$display("test broadcast done");
		send("0B0300C8000426");
		expect_reply("0B830171");
		send("0B06019000015D");
		expect_reply("0B86026D");
		$display("test errors done");
		rx_err_i = 1'b1;
		send("0B08000004D217");
		rx_err_i = 1'b0;
		expect_drop();
		send("0C08000004D216");
		expect_drop();
		$display("test discard done");
		ascii_mode_i = 1'b0;
		tick(2);
		send_rtu("0B08000004D2A1B2");
		expect_reply("0B08000004D2A1B2");
		check(mbw_master_model_i.flg[base + 7][0], 1'b0);
		send_rtu("0B0300C800044477");
		expect_reply("0B8301");
		check(mbw_master_model_i.flg[base + 2][0], 1'b1);
		ascii_mode_i = 1'b1;
		$display("test rtu done");
		send_raw(":0B06");
		tick(150);
		check(busy_o, 1'b1);
		w = 0;
		while (frame_drop_o !== 1'b1 && w < 150)
		begin
			tick(1);
			w++;
		end
		check(frame_drop_o, 1'b1);
		if (w == 150)
			give_verdict();
		expect_none();
		$display("test gap done");
		give_verdict();
	end
endmodule
